// File: rtl/uefr_top.sv
// module: per-channel enhanced feature register bank on the parallel register port
//
// Summary of operation
// RULE_01: trigger register at 0 when line control BF
// RULE_02: bit 7 picks receive or transmit trigger
// RULE_03: trigger value limited to 0x00..0x40
// RULE_04: level count readable at 0 when BF
// RULE_05: count bit 7 names the reported fifo
// RULE_06: each count read swaps reported fifo
// RULE_07: count bits 6:0 give characters held
// RULE_08: feature control at 1, reset 20
// RULE_09: feature bits 5:4 pick trigger table
// RULE_10: feature bits 3:0 pick hysteresis size
// RULE_11: hysteresis applies only with table D
// RULE_12: alternate function at 2, gated access
// RULE_13: alternate bit 1 picks multifunction source
// RULE_14: advanced special at 4, gated access
// RULE_15: advanced bit 7 opens rs485 register
// RULE_16: advanced bit 6 disables transmitter
// RULE_17: advanced bit 5 disables receiver
// RULE_18: bit 4 clear gives 3/16 pulses
// RULE_19: bit 4 set gives 1/4 pulses
// RULE_20: offset 0 writes trigger, reads count
`timescale 1ns/1ps
module uefr_top
	import uefr_pkg::*;
(
	input wire logic SYS_CLK_I, // uart clock
	input wire logic RST_N_I, // synchronous reset, active low
	input wire logic [2:0] ADDR_I, // register address
	input wire logic WR_I, // one-cycle write strobe
	input wire logic RD_I, // one-cycle read strobe
	input wire logic [7:0] WDATA_I, // write data
	output logic [7:0] RDATA_O, // registered read data
	output logic RHIT_O, // read hit this bank, registered
	input wire logic [7:0] LINE_CONTROL_I, // line control register contents
	input wire logic [7:0] ENHANCED_FUNCTION_I, // enhanced function register contents
	input wire logic MODEM_CONTROL_BIT3_I, // modem control bit 3
	input wire logic BAUD_CLK_I, // baud clock, true level
	input wire logic [6:0] RX_FIFO_LEVEL_I, // receive fifo characters
	input wire logic [6:0] TX_FIFO_LEVEL_I, // transmit fifo characters
	output logic [6:0] RECEIVE_TRIGGER_LEVEL_O, // receive trigger level, table D
	output logic [6:0] TRANSMIT_TRIGGER_LEVEL_O, // transmit trigger level, table D
	output uefr_pkg::uefr_table_e TABLE_SEL_O, // selected trigger table
	output uefr_pkg::uefr_hyst_t HYSTERESIS_O, // auto-rts hysteresis characters
	output logic MULTIFUNCTION_OUTPUT_N_O, // multifunction pin, active low
	output logic TX_DISABLE_O, // transmitter disabled
	output logic RX_DISABLE_O, // receiver disabled
	output logic RS485_ACCESS_O, // rs485 register reachable
	output logic [1:0] IR_PULSE_O // infrared pulse width code
);
	uefr_cfg_if cfg (); // bank contents to the helpers
	logic enh_sel; // line control holds the key
	logic dlab_sel; // divisor bit set, key absent
	logic [6:0] rx_trig_r; // receive trigger level
	logic [6:0] tx_trig_r; // transmit trigger level
	logic cnt_sel_r; // 0 reports receive, 1 transmit
	logic [7:0] feature_r; // feature control
	logic [7:0] alt_r; // alternate function
	logic [7:0] adv_r; // advanced special
	logic wr_trig, wr_feat, wr_alt, wr_adv; // decoded write strobes
	logic rd_cnt, rd_feat, rd_alt, rd_adv; // decoded read strobes
	logic [7:0] rdata_nxt; // read mux result

	// every assertion below samples on the uart clock and sleeps through reset
	default clocking cb_sys @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	// decode; key and divisor window are mutually exclusive
	assign enh_sel = (LINE_CONTROL_I == LINE_CTRL_ENH_KEY);
	assign dlab_sel = LINE_CONTROL_I[LINE_CTRL_DLAB_BIT] && !enh_sel;
	assign wr_trig = WR_I && enh_sel && (ADDR_I == OFS_TRIG_LEVEL); // see RULE_01 RULE_20
	assign rd_cnt = RD_I && enh_sel && (ADDR_I == OFS_LEVEL_COUNT); // see RULE_04 RULE_20
	assign wr_feat = WR_I && enh_sel && (ADDR_I == OFS_FEATURE_CTRL); // see RULE_08
	assign rd_feat = RD_I && enh_sel && (ADDR_I == OFS_FEATURE_CTRL);
	assign wr_alt = WR_I && dlab_sel && !ENHANCED_FUNCTION_I[ENH_FUNC_SEL_BIT]
		&& (ADDR_I == OFS_ALT_FUNC); // see RULE_12
	assign rd_alt = RD_I && dlab_sel && !ENHANCED_FUNCTION_I[ENH_FUNC_SEL_BIT]
		&& (ADDR_I == OFS_ALT_FUNC);
	assign wr_adv = WR_I && dlab_sel && ENHANCED_FUNCTION_I[ENH_FUNC_SEL_BIT]
		&& (ADDR_I == OFS_ADV_SPECIAL); // see RULE_14
	assign rd_adv = RD_I && dlab_sel && ENHANCED_FUNCTION_I[ENH_FUNC_SEL_BIT]
		&& (ADDR_I == OFS_ADV_SPECIAL);

	// trigger levels; out-of-range values are software's fault and are clamped
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			rx_trig_r <= RST_TRIG[6:0];
			tx_trig_r <= RST_TRIG[6:0];
		end
		else if (wr_trig)
		begin
			if (WDATA_I[TRIG_SEL_BIT]) // see RULE_02
				tx_trig_r <= (WDATA_I[6:0] > TRIG_MAX) ? TRIG_MAX : WDATA_I[6:0]; // see RULE_03
			else
				rx_trig_r <= (WDATA_I[6:0] > TRIG_MAX) ? TRIG_MAX : WDATA_I[6:0]; // see RULE_03
		end
	end

	// fifo report select flips after every count read
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
			cnt_sel_r <= RST_COUNT[CNT_SEL_BIT];
		else if (rd_cnt)
			cnt_sel_r <= !cnt_sel_r; // see RULE_06
	end

	// control registers; feature and alternate reserved bits never store, advanced special stores all bits
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			feature_r <= RST_FEATURE;
			alt_r <= RST_ALT;
			adv_r <= RST_ADV;
		end
		else
		begin
			if (wr_feat)
				feature_r <= WDATA_I & FEAT_WR_MASK; // see RULE_08
			if (wr_alt)
				alt_r <= WDATA_I & ALT_WR_MASK; // see RULE_13
			if (wr_adv)
				adv_r <= WDATA_I; // see RULE_14
		end
	end

	// read mux; unmatched reads return zero and no hit
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (rd_cnt) // see RULE_05 RULE_07
			rdata_nxt = {cnt_sel_r, cnt_sel_r ? TX_FIFO_LEVEL_I : RX_FIFO_LEVEL_I};
		else if (rd_feat)
			rdata_nxt = feature_r;
		else if (rd_alt)
			rdata_nxt = alt_r;
		else if (rd_adv)
			rdata_nxt = adv_r;
	end

	// read data register, held until the next read
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			RDATA_O <= 8'h00;
			RHIT_O <= 1'b0;
		end
		else
		begin
			RHIT_O <= rd_cnt || rd_feat || rd_alt || rd_adv;
			if (RD_I)
				RDATA_O <= rdata_nxt;
		end
	end

	assign cfg.feature = feature_r;
	assign cfg.alt = alt_r;
	assign cfg.adv = adv_r;
	assign RECEIVE_TRIGGER_LEVEL_O = rx_trig_r;
	assign TRANSMIT_TRIGGER_LEVEL_O = tx_trig_r;

	uefr_hyst u_hyst (
		.cfg(cfg),
		.hyst_o(HYSTERESIS_O),
		.table_o(TABLE_SEL_O)
	);

	uefr_outsel u_outsel (
		.cfg(cfg),
		.modem_ctrl_bit3_i(MODEM_CONTROL_BIT3_I),
		.baud_clk_i(BAUD_CLK_I),
		.multifunction_output_n_o(MULTIFUNCTION_OUTPUT_N_O),
		.tx_disable_o(TX_DISABLE_O),
		.rx_disable_o(RX_DISABLE_O),
		.rs485_access_o(RS485_ACCESS_O),
		.ir_pulse_o(IR_PULSE_O)
	);

	// assertions guarding register behaviour
	// level count: select swaps only on a hit read, data names the right fifo
	a_count_toggle: assert property ( // see RULE_06
		rd_cnt |=> cnt_sel_r != $past(cnt_sel_r))
		else $error("level count select did not toggle");
	a_count_flag: assert property ( // see RULE_05
		rd_cnt |=> RDATA_O[CNT_SEL_BIT] == !cnt_sel_r)
		else $error("level count flag wrong");
	a_count_value: assert property ( // see RULE_07
		rd_cnt && !cnt_sel_r |=> RDATA_O[6:0] == $past(RX_FIFO_LEVEL_I))
		else $error("receive count wrong");
	a_count_tx_value: assert property ( // see RULE_07
		rd_cnt && cnt_sel_r |=> RDATA_O[6:0] == $past(TX_FIFO_LEVEL_I))
		else $error("transmit count wrong");
	a_count_hold: assert property ( // see RULE_06
		!rd_cnt |=> $stable(cnt_sel_r))
		else $error("level count select moved without a read");
	a_count_key: assert property ( // see RULE_04
		RD_I && ADDR_I == OFS_LEVEL_COUNT && !enh_sel |=> !RHIT_O && RDATA_O == 8'h00)
		else $error("level count readable without key");
	// trigger levels: key, target select and legal range
	a_trig_target: assert property ( // see RULE_02
		wr_trig && WDATA_I[TRIG_SEL_BIT] |=> $stable(rx_trig_r))
		else $error("transmit write touched receive trigger");
	a_trig_rx_keep: assert property ( // see RULE_02
		wr_trig && !WDATA_I[TRIG_SEL_BIT] |=> $stable(tx_trig_r))
		else $error("receive write touched transmit trigger");
	a_trig_rx_load: assert property ( // see RULE_02
		wr_trig && !WDATA_I[TRIG_SEL_BIT] && WDATA_I[6:0] <= TRIG_MAX
		|=> rx_trig_r == $past(WDATA_I[6:0]))
		else $error("receive trigger not loaded");
	a_trig_tx_load: assert property ( // see RULE_02
		wr_trig && WDATA_I[TRIG_SEL_BIT] && WDATA_I[6:0] <= TRIG_MAX
		|=> tx_trig_r == $past(WDATA_I[6:0]))
		else $error("transmit trigger not loaded");
	a_trig_range: assert property ( // see RULE_03
		(rx_trig_r <= TRIG_MAX) && (tx_trig_r <= TRIG_MAX))
		else $error("trigger out of range");
	a_trig_gate: assert property ( // see RULE_01
		WR_I && !enh_sel |=> $stable(tx_trig_r))
		else $error("trigger written without key");
	a_trig_key_rx: assert property ( // see RULE_01
		WR_I && !enh_sel |=> $stable(rx_trig_r))
		else $error("receive trigger written without key");
	a_trig_offset: assert property ( // see RULE_01
		WR_I && ADDR_I != OFS_TRIG_LEVEL |=> $stable(rx_trig_r) && $stable(tx_trig_r))
		else $error("trigger written at another offset");
	// offset 0 is shared: a write never swaps the count, a read never loads a trigger
	a_write_no_swap: assert property ( // see RULE_20
		wr_trig |=> $stable(cnt_sel_r))
		else $error("trigger write swapped the count select");
	a_read_keep_trig: assert property ( // see RULE_20
		rd_cnt |=> $stable(rx_trig_r) && $stable(tx_trig_r))
		else $error("count read changed a trigger");
	// feature control: key, reserved bits, table and hysteresis
	a_feat_resv: assert property ( // see RULE_08
		rd_feat |=> RDATA_O[7:6] == 2'h0)
		else $error("feature reserved bits nonzero");
	a_feat_resv_store: assert property ( // see RULE_08
		wr_feat |=> feature_r[7:6] == 2'h0)
		else $error("feature reserved bits stored");
	a_feat_key: assert property ( // see RULE_08
		WR_I && !enh_sel |=> $stable(feature_r))
		else $error("feature control written without key");
	a_table_sel: assert property ( // see RULE_09
		wr_feat |=> TABLE_SEL_O == uefr_table_e'($past(WDATA_I[FEAT_TABLE_HI:FEAT_TABLE_LO])))
		else $error("table select not taken");
	a_table_hold: assert property ( // see RULE_09
		!wr_feat |=> $stable(TABLE_SEL_O))
		else $error("table select moved without a write");
	a_hyst_gate: assert property ( // see RULE_11
		TABLE_SEL_O != UEFR_TAB_D |-> HYSTERESIS_O == 6'h00)
		else $error("hysteresis outside table D");
	a_hyst_code: assert property ( // see RULE_10
		feature_r[5:0] == 6'h3C |-> HYSTERESIS_O == 6'h0C)
		else $error("hysteresis code 1100 wrong");
	a_hyst_table_d: assert property ( // see RULE_10 RULE_11
		TABLE_SEL_O == UEFR_TAB_D && feature_r[FEAT_HYST_HI:0] == 4'h5 |-> HYSTERESIS_O == 6'h10)
		else $error("hysteresis code 0101 wrong");
	// alternate function and the multifunction pin
	a_alt_gate: assert property ( // see RULE_12
		WR_I && ENHANCED_FUNCTION_I[ENH_FUNC_SEL_BIT] |=> $stable(alt_r))
		else $error("alternate function written in wrong mode");
	a_alt_key: assert property ( // see RULE_12
		WR_I && enh_sel |=> $stable(alt_r))
		else $error("alternate function written under key");
	a_alt_resv: assert property ( // see RULE_13
		wr_alt |=> (alt_r & ~ALT_WR_MASK) == 8'h00)
		else $error("alternate function reserved bits stored");
	a_mfo_source: assert property ( // see RULE_13
		!alt_r[ALT_OUT_SEL_BIT] |-> MULTIFUNCTION_OUTPUT_N_O == !MODEM_CONTROL_BIT3_I)
		else $error("multifunction pin source wrong");
	a_mfo_baud: assert property ( // see RULE_13
		alt_r[ALT_OUT_SEL_BIT] |-> MULTIFUNCTION_OUTPUT_N_O == !BAUD_CLK_I)
		else $error("multifunction pin baud source wrong");
	// advanced special: gating and the controls it drives
	a_adv_gate: assert property ( // see RULE_14
		WR_I && (enh_sel || !ENHANCED_FUNCTION_I[ENH_FUNC_SEL_BIT]) |=> $stable(adv_r))
		else $error("advanced special written in wrong mode");
	a_read_refused: assert property ( // see RULE_12 RULE_14
		RD_I && !enh_sel && !dlab_sel |=> !RHIT_O && RDATA_O == 8'h00)
		else $error("read answered outside the access window");
	a_tx_disable: assert property ( // see RULE_16
		wr_adv |=> TX_DISABLE_O == $past(WDATA_I[ADV_TX_DIS_BIT]))
		else $error("transmitter disable not taken");
	a_rx_disable: assert property ( // see RULE_17
		wr_adv |=> RX_DISABLE_O == $past(WDATA_I[ADV_RX_DIS_BIT]))
		else $error("receiver disable not taken");
	a_adv_hold: assert property ( // see RULE_16 RULE_17
		!wr_adv |=> $stable(TX_DISABLE_O) && $stable(RX_DISABLE_O))
		else $error("channel disables moved without a write");
	a_ir_pulse: assert property ( // see RULE_18
		wr_adv && !WDATA_I[ADV_IR_FAST_BIT] |=> IR_PULSE_O == IR_PULSE_3_16)
		else $error("infrared slow mode wrong");
	a_ir_fast: assert property ( // see RULE_19
		wr_adv && WDATA_I[ADV_IR_FAST_BIT] |=> IR_PULSE_O == IR_PULSE_1_4)
		else $error("infrared fast mode wrong");
	a_rs485_gate: assert property ( // see RULE_15
		wr_adv |=> RS485_ACCESS_O == $past(WDATA_I[ADV_RS485_BIT]))
		else $error("rs485 access bit not taken");
	a_ir_hold: assert property ( // see RULE_15 RULE_18 RULE_19
		!wr_adv |=> $stable(IR_PULSE_O) && $stable(RS485_ACCESS_O))
		else $error("infrared or rs485 control moved without a write");
	// read port: data stands until the next read, hit only after a read
	a_rdata_hold: assert property ( // see RULE_04
		!RD_I |=> $stable(RDATA_O))
		else $error("read data changed without a read");
	a_rhit_pulse: assert property ( // see RULE_04
		RHIT_O |-> $past(RD_I))
		else $error("read hit without a read");
endmodule

// File: pkg/uefr_pkg.sv
// package: offsets, fields, reset values and hysteresis type of the enhanced feature registers
package uefr_pkg;
	localparam logic [2:0] OFS_TRIG_LEVEL = 3'h0; // write-only trigger level, shares 0 with count
	localparam logic [2:0] OFS_LEVEL_COUNT = 3'h0; // read-only fifo level count
	localparam logic [2:0] OFS_FEATURE_CTRL = 3'h1; // feature control
	localparam logic [2:0] OFS_ALT_FUNC = 3'h2; // alternate function
	localparam logic [2:0] OFS_ADV_SPECIAL = 3'h4; // advanced special
	localparam logic [7:0] LINE_CTRL_ENH_KEY = 8'hBF; // line control value opening the bank
	localparam int LINE_CTRL_DLAB_BIT = 7; // line control divisor-latch bit
	localparam int ENH_FUNC_SEL_BIT = 4; // enhanced function bit 4 picks alt/adv
	localparam logic [7:0] RST_TRIG = 8'h00; // trigger level reset
	localparam logic [7:0] RST_COUNT = 8'h00; // level count reset
	localparam logic [7:0] RST_FEATURE = 8'h20; // feature control reset
	localparam logic [7:0] RST_ALT = 8'h00; // alternate function reset
	localparam logic [7:0] RST_ADV = 8'h00; // advanced special reset
	localparam logic [6:0] TRIG_MAX = 7'h40; // largest legal table D trigger
	localparam int TRIG_SEL_BIT = 7; // trigger write target select
	localparam int CNT_SEL_BIT = 7; // level count fifo flag
	localparam int FEAT_TABLE_HI = 5; // table select high bit
	localparam int FEAT_TABLE_LO = 4; // table select low bit
	localparam int FEAT_HYST_HI = 3; // hysteresis select high bit
	localparam logic [1:0] TABLE_D = 2'h3; // table D code
	localparam int ALT_OUT_SEL_BIT = 1; // multifunction output select
	localparam int ADV_RS485_BIT = 7; // rs485 control access enable
	localparam int ADV_TX_DIS_BIT = 6; // transmitter disable
	localparam int ADV_RX_DIS_BIT = 5; // receiver disable
	localparam int ADV_IR_FAST_BIT = 4; // infrared fast mode
	localparam logic [7:0] ALT_WR_MASK = 8'h02; // writable bits of alternate function
	localparam logic [7:0] FEAT_WR_MASK = 8'h3F; // writable bits of feature control
	localparam logic [1:0] IR_PULSE_3_16 = 2'h0; // 3/16 bit-time pulse, up to 115.2 kbps
	localparam logic [1:0] IR_PULSE_1_4 = 2'h1; // 1/4 bit-time pulse, up to 1.152 Mbps
	typedef logic [5:0] uefr_hyst_t; // hysteresis in characters
	typedef enum logic [1:0] {UEFR_TAB_A, UEFR_TAB_B, UEFR_TAB_C, UEFR_TAB_D} uefr_table_e;
endpackage

// File: pkg/uefr_cfg_if.sv
// interface: raw register contents carried from the register bank to the output logic
`timescale 1ns/1ps
interface uefr_cfg_if;
	logic [7:0] feature; // feature control contents
	logic [7:0] alt; // alternate function contents
	logic [7:0] adv; // advanced special contents
	modport src (output feature, alt, adv);
	modport dst (input feature, alt, adv);
endinterface

// File: rtl/uefr_hyst.sv
// module: auto-rts hysteresis decode, gated to table D
`timescale 1ns/1ps
module uefr_hyst
	import uefr_pkg::*;
(
	uefr_cfg_if.dst cfg, // configuration from the bank
	output uefr_pkg::uefr_hyst_t hyst_o, // hysteresis characters
	output uefr_pkg::uefr_table_e table_o // selected trigger table
);
	logic [3:0] sel; // hysteresis select code
	uefr_hyst_t raw; // decoded value before gating
	assign sel = cfg.feature[FEAT_HYST_HI:0];
	assign table_o = uefr_table_e'(cfg.feature[FEAT_TABLE_HI:FEAT_TABLE_LO]); // see RULE_09
	// table lookup; codes 1100..1111 are out of order on purpose
	always_comb
	begin
		case (sel) // see RULE_10
			4'h0: raw = 6'h00;
			4'h1: raw = 6'h04;
			4'h2: raw = 6'h06;
			4'h3: raw = 6'h08;
			4'h4: raw = 6'h08;
			4'h5: raw = 6'h10;
			4'h6: raw = 6'h18;
			4'h7: raw = 6'h20;
			4'h8: raw = 6'h28;
			4'h9: raw = 6'h2C;
			4'hA: raw = 6'h30;
			4'hB: raw = 6'h34;
			4'hC: raw = 6'h0C;
			4'hD: raw = 6'h14;
			4'hE: raw = 6'h1C;
			default: raw = 6'h24;
		endcase
	end
	// other tables carry no hysteresis
	assign hyst_o = (table_o == UEFR_TAB_D) ? raw : 6'h00; // see RULE_11
endmodule

// File: rtl/uefr_outsel.sv
// module: multifunction pin source, channel disables and infrared pulse select
`timescale 1ns/1ps
module uefr_outsel
	import uefr_pkg::*;
(
	uefr_cfg_if.dst cfg, // configuration from the bank
	input wire logic modem_ctrl_bit3_i, // modem control bit 3
	input wire logic baud_clk_i, // baud clock output, true level
	output logic multifunction_output_n_o, // multifunction pin, active low
	output logic tx_disable_o, // transmitter disabled
	output logic rx_disable_o, // receiver disabled
	output logic rs485_access_o, // rs485 register reachable
	output logic [1:0] ir_pulse_o // infrared pulse width code
);
	// pin source chosen by one bit, both sources inverted
	assign multifunction_output_n_o = cfg.alt[ALT_OUT_SEL_BIT] ? ~baud_clk_i
		: ~modem_ctrl_bit3_i; // see RULE_13
	assign rs485_access_o = cfg.adv[ADV_RS485_BIT]; // see RULE_15
	assign tx_disable_o = cfg.adv[ADV_TX_DIS_BIT]; // see RULE_16
	assign rx_disable_o = cfg.adv[ADV_RX_DIS_BIT]; // see RULE_17
	// slow mode 3/16, fast mode 1/4
	assign ir_pulse_o = cfg.adv[ADV_IR_FAST_BIT] ? IR_PULSE_1_4 // see RULE_19
		: IR_PULSE_3_16; // see RULE_18
endmodule

// File: sim/uefr_host.sv
// host processor model driving the register port of one channel
`timescale 1ns/1ps
module uefr_host (
	input wire logic clk_i, // uart clock
	output logic [2:0] addr_o, // register address
	output logic wr_o, // write strobe
	output logic rd_o, // read strobe
	output logic [7:0] wdata_o, // write data
	input wire logic [7:0] rdata_i, // read data
	input wire logic rhit_i // read hit flag
);
	// bus idle at time zero, address parked on an unmapped offset
	initial
	begin
		addr_o = 3'h7;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// one-cycle write; data inverted after release so a stale value never looks valid
	task automatic write(input logic [2:0] a, input logic [7:0] v);
	begin
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= v;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~v;
	end
	endtask
	// one-cycle read; the answer is taken once the sampling edge has landed
	task automatic read(input logic [2:0] a, output logic [7:0] v, output logic hit);
	begin
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		v = rdata_i;
		hit = rhit_i;
	end
	endtask
endmodule

// File: sim/uart_enhanced_feature_registers_tb.sv
// self-checking bench for the enhanced feature register bank of one channel
`timescale 1ns/1ps
module uart_enhanced_feature_registers_tb;
	import uefr_pkg::*;
	logic clk, rst_n, wr, rd, modem3, baud; // clock, reset, strobes, pin sources
	logic [2:0] addr; // register address
	logic [7:0] wdata, rdata, line, enh, d; // bus data and gating registers
	logic rhit, h, mf_n, txd, rxd, rs485; // hit flag and single-bit outputs
	logic [6:0] rxl, txl, rxt, txt; // fifo levels and trigger levels
	logic [1:0] ir; // infrared pulse code
	uefr_table_e tsel; // selected trigger table
	uefr_hyst_t hyst; // hysteresis characters
	int miscompares, comparisons, cycles; // report counters
	// rows: line control, enhanced function, offset, write data, read back, hit
	logic [7:0] rows [6][6] = '{'{8'hBF, 8'h00, 8'h01, 8'h35, 8'h35, 8'h01},
		'{8'hBF, 8'h00, 8'h01, 8'hFF, 8'h3F, 8'h01}, '{8'h80, 8'h00, 8'h02, 8'hFF, 8'h02, 8'h01},
		'{8'h83, 8'h10, 8'h04, 8'hA5, 8'hA5, 8'h01}, '{8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00},
		'{8'h80, 8'h00, 8'h03, 8'hFF, 8'h00, 8'h00}};
	logic [5:0] hyst_tab [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
		6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24}; // characters per code
	logic [7:0] advv [2] = '{8'hD0, 8'h20}; // advanced special patterns
	uefr_host host_u (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
		.rdata_i(rdata), .rhit_i(rhit));
	uefr_top dut_u (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
		.WDATA_I(wdata), .RDATA_O(rdata), .RHIT_O(rhit), .LINE_CONTROL_I(line),
		.ENHANCED_FUNCTION_I(enh), .MODEM_CONTROL_BIT3_I(modem3), .BAUD_CLK_I(baud),
		.RX_FIFO_LEVEL_I(rxl), .TX_FIFO_LEVEL_I(txl), .RECEIVE_TRIGGER_LEVEL_O(rxt),
		.TRANSMIT_TRIGGER_LEVEL_O(txt), .TABLE_SEL_O(tsel), .HYSTERESIS_O(hyst),
		.MULTIFUNCTION_OUTPUT_N_O(mf_n), .TX_DISABLE_O(txd), .RX_DISABLE_O(rxd),
		.RS485_ACCESS_O(rs485), .IR_PULSE_O(ir));
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, far above the roughly 150 cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			miscompares++;
			give_verdict();
		end
	end
	// compare with four-state equality so an unknown never matches
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
	begin
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	// step past the next edge so its updates have landed
	task automatic tick();
	begin
		@(posedge clk);
		#1;
	end
	endtask
	// gating registers change at an edge, before the next strobe
	task automatic set_key(input logic [7:0] l, input logic [7:0] e);
	begin
		@(posedge clk);
		line <= l;
		enh <= e;
	end
	endtask
	// closing report, also reached from the hang guard
	task automatic give_verdict();
	begin
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		line = 8'h00;
		enh = 8'h00;
		modem3 = 1'b0;
		baud = 1'b0;
		rxl = 7'h11;
		txl = 7'h2A;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			set_key(rows[i][0], rows[i][1]);
			host_u.write(rows[i][2][2:0], rows[i][3]);
			host_u.read(rows[i][2][2:0], d, h);
			chk("table read", rows[i][4], d);
			chk("table hit", rows[i][5], {7'h00, h});
		end
		$display("test register table done");
		set_key(8'hBF, 8'h00);
		host_u.write(3'h0, 8'h25);
		host_u.write(3'h0, 8'hC0);
		tick();
		chk("rx trigger", 8'h25, {1'b0, rxt});
		chk("tx trigger", 8'h40, {1'b0, txt});
		$display("test trigger levels done");
		// mid-run reset: everything back to reset values
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		tick();
		chk("triggers after reset", RST_TRIG, {1'b0, rxt | txt});
		chk("outputs after reset", 8'h00, {3'b000, rs485, txd, rxd, ir});
		set_key(8'hBF, 8'h00);
		host_u.read(3'h1, d, h);
		chk("feature reset", RST_FEATURE, d);
		set_key(8'h83, 8'h00);
		host_u.read(3'h2, d, h);
		chk("alt reset", RST_ALT, d);
		$display("test reset done");
		// level count alternates, refused reads do not swap it
		set_key(8'hBF, 8'h00);
		host_u.read(3'h0, d, h);
		chk("count rx", {1'b0, rxl}, d);
		host_u.read(3'h0, d, h);
		chk("count tx", {1'b1, txl}, d);
		set_key(8'h80, 8'h00);
		rxl <= 7'h40;
		host_u.read(3'h0, d, h);
		chk("count refused", 8'h00, d | {7'h00, h});
		set_key(8'hBF, 8'h00);
		host_u.read(3'h0, d, h);
		chk("count rx again", {1'b0, rxl}, d);
		$display("test level count done");
		for (int c = 0; c < 16; c++)
		begin
			host_u.write(3'h1, {4'h3, c[3:0]});
			tick();
			chk("hysteresis", {2'b00, hyst_tab[c]}, {2'b00, hyst});
		end
		for (int t = 0; t < 4; t++)
		begin
			host_u.write(3'h1, {2'b00, t[1:0], 4'h5});
			tick();
			chk("table select", {6'h00, t[1:0]}, {6'h00, tsel});
			chk("gated hyst", (t == 3) ? 8'h10 : 8'h00, {2'b00, hyst});
		end
		$display("test feature control done");
		// modem bit and baud clock always differ, so the source is visible
		set_key(8'h80, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			host_u.write(3'h2, {6'h00, k[1], 1'b0});
			@(posedge clk);
			modem3 <= k[0];
			baud <= ~k[0];
			tick();
			chk("multifunction pin", {7'h00, k[1] ? k[0] : ~k[0]}, {7'h00, mf_n});
		end
		set_key(8'h80, 8'h10);
		foreach (advv[j])
		begin
			host_u.write(3'h4, advv[j]);
			tick();
			chk("adv outputs", {3'b000, advv[j][7:5], advv[j][4] ? IR_PULSE_1_4 : IR_PULSE_3_16},
				{3'b000, rs485, txd, rxd, ir});
		end
		host_u.read(3'h2, d, h);
		chk("alt refused", 8'h00, d | {7'h00, h});
		set_key(8'h03, 8'h10);
		host_u.read(3'h4, d, h);
		chk("adv refused", 8'h00, d | {7'h00, h});
		$display("test outputs and gating done");
		give_verdict();
	end
endmodule
